// [pkg/spfs_regs.svh]
// Purpose: register map, reset values and checker constants for the
//          shared pin function select block
// Assumes: 8-bit register port, one register per 4-byte step
// Notes:   a bit set in the analog enable register means converter use
`ifndef SPFS_REGS_SVH
`define SPFS_REGS_SVH

// register addresses
`define SPFS_A_P6_DATA   8'h00
`define SPFS_A_P6_PIN    8'h04
`define SPFS_A_P7_DATA   8'h08
`define SPFS_A_P7_DIR    8'h0c
`define SPFS_A_P7_PIN    8'h10
`define SPFS_A_P8_DATA   8'h14
`define SPFS_A_P8_DIR    8'h18
`define SPFS_A_P8_PIN    8'h1c
`define SPFS_A_ANA_EN    8'h20
`define SPFS_A_MODE      8'h24
`define SPFS_A_CONFLICT  8'h28

// reset values
`define SPFS_RST_ANA_EN  8'hff
`define SPFS_RST_P6_DATA 8'hff
`define SPFS_RST_P7      3'h0
`define SPFS_RST_P8      2'h0
`define SPFS_RST_CONF    5'h00

// checker helpers
`define SPFS_AGE_MAX     2'h3
`define SPFS_AGE_STEP    2'h1

`endif

// [pkg/spfs_pkg.sv]
// Purpose: shared types of the shared pin function select block
// Assumes: nothing beyond the register header
// Notes:   mode capture runs once after each reset release
package spfs_pkg;

  typedef logic [7:0] spfs_byte_t;
  typedef logic [2:0] spfs_mode_t;

  // waits for the synchroniser to fill before taking the straps
  typedef enum logic [1:0] {
    SPFS_CAP_FILL = 2'b00,
    SPFS_CAP_SYNC = 2'b01,
    SPFS_CAP_TAKE = 2'b10,
    SPFS_CAP_DONE = 2'b11
  } spfs_cap_state_t;

endpackage : spfs_pkg

// [logic/spfs_sync.sv]
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels, not multi-bit words
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module spfs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // levels
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= {WIDTH{1'b0}};
      hold_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= d_in;
      hold_ff <= meta_ff;
    end
  end

  assign q_out = hold_ff;

endmodule : spfs_sync

`default_nettype wire

// [logic/spfs_pin_mux.sv]
// Purpose: selects port or peripheral use for one group of shared pins
// Assumes: peripheral enables and waveforms come from logic on CORE_CLK_IN
// Notes:   pin drivers are combinational from flops so a register write
//          changes the pin in the very next cycle
`include "spfs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module spfs_pin_mux (
  // clock and reset
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RST_N_IN,
  // register port
  input  wire logic [7:0]           REG_ADDR_IN,
  input  wire spfs_pkg::spfs_byte_t REG_WDATA_IN,
  input  wire logic                 REG_WR_IN,
  input  wire logic                 REG_RD_IN,
  output var  spfs_pkg::spfs_byte_t REG_RDATA_OUT,
  // peripheral controls
  input  wire logic [1:0]           PULSE_GEN_WAVE_IN,
  input  wire logic [1:0]           PULSE_GEN_OUT_EN_IN,
  input  wire logic [7:0]           EXT_IRQ_EN_IN,
  input  wire logic [1:0]           RELOAD_TIMER_EVENT_EN_IN,
  input  wire logic                 CONV_TRIGGER_EN_IN,
  // peripheral inputs
  output logic      [7:0]           EXT_IRQ_OUT,
  output logic                      RELOAD_TIMER0_EVENT_OUT,
  output logic                      RELOAD_TIMER1_EVENT_OUT,
  output logic                      CONV_TRIGGER_OUT,
  output logic      [7:0]           ANALOG_IN_PINS_SEL_OUT,
  output var  spfs_pkg::spfs_mode_t MODE_OUT,
  output logic                      MODE_VALID_OUT,
  // interrupt-only pins
  input  wire logic [3:0]           EXT_IRQ_IN_LOW_IN,
  // port7 pins
  input  wire logic [1:0]           PORT7_SHARED_BITS_IN,
  output logic      [1:0]           PORT7_SHARED_BITS_OUT,
  output logic      [1:0]           PORT7_SHARED_BITS_OE_OUT,
  input  wire logic                 PORT7_BIT6_IN,
  output logic                      PORT7_BIT6_OUT,
  output logic                      PORT7_BIT6_OE_OUT,
  // port6 pins
  input  wire logic [7:0]           PORT6_OPENDRAIN_BITS_IN,
  output logic      [7:0]           PORT6_OPENDRAIN_BITS_OUT,
  output logic      [7:0]           PORT6_OPENDRAIN_BITS_OE_OUT,
  // port8 pins
  input  wire logic                 PORT8_BIT0_IN,
  output logic                      PORT8_BIT0_OUT,
  output logic                      PORT8_BIT0_OE_OUT,
  input  wire logic                 PORT8_BIT1_IN,
  output logic                      PORT8_BIT1_OUT,
  output logic                      PORT8_BIT1_OE_OUT,
  // mode straps
  input  wire logic [2:0]           MODE_SELECT_PINS_IN
);

  import spfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic wr_hit(input logic       stb,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    return stb && (addr == target);
  endfunction : wr_hit

  function automatic logic drv_val(input logic fn_en,
                                   input logic fn_val,
                                   input logic port_val);
    return fn_en ? fn_val : port_val;
  endfunction : drv_val

  function automatic logic drv_en(input logic fn_en,
                                  input logic dir);
    return fn_en | dir;
  endfunction : drv_en

  ////////////////////////////////////////////////////////////////////////
  // pin input synchronisation

  logic [19:0]     pin_raw;
  logic [19:0]     pin_sync;
  logic [3:0]      irq_low_s;
  logic [1:0]      sh_s;
  logic            b76_s;
  logic [7:0]      p6_s;
  logic            b80_s;
  logic            b81_s;
  spfs_mode_t      mode_s;

  assign pin_raw = {MODE_SELECT_PINS_IN, PORT8_BIT1_IN, PORT8_BIT0_IN,
                    PORT6_OPENDRAIN_BITS_IN, PORT7_BIT6_IN,
                    PORT7_SHARED_BITS_IN, EXT_IRQ_IN_LOW_IN};

  spfs_sync #(
    .WIDTH (20)
  ) u_pin_sync (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (pin_raw),
    .q_out    (pin_sync)
  );

  assign {mode_s, b81_s, b80_s, p6_s, b76_s, sh_s, irq_low_s} = pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // port registers

  logic [7:0]      p6_data_ff;
  logic [2:0]      p7_data_ff;
  logic [2:0]      p7_dir_ff;
  logic [1:0]      p8_data_ff;
  logic [1:0]      p8_dir_ff;
  logic [7:0]      ana_en_ff;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      p6_data_ff <= `SPFS_RST_P6_DATA;
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P6_DATA)) begin
      p6_data_ff <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      p7_data_ff <= `SPFS_RST_P7;
      p7_dir_ff  <= `SPFS_RST_P7;
    end else begin
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P7_DATA)) begin
        p7_data_ff <= REG_WDATA_IN[2:0];
      end
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P7_DIR)) begin
        p7_dir_ff <= REG_WDATA_IN[2:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      p8_data_ff <= `SPFS_RST_P8;
      p8_dir_ff  <= `SPFS_RST_P8;
    end else begin
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P8_DATA)) begin
        p8_data_ff <= REG_WDATA_IN[1:0];
      end
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P8_DIR)) begin
        p8_dir_ff <= REG_WDATA_IN[1:0];
      end
    end
  end

  // analog use after reset keeps the converter pins undriven
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ana_en_ff <= `SPFS_RST_ANA_EN;
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_ANA_EN)) begin
      ana_en_ff <= REG_WDATA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wave
      assign PORT7_SHARED_BITS_OUT[gi] = drv_val(PULSE_GEN_OUT_EN_IN[gi],
        PULSE_GEN_WAVE_IN[gi], p7_data_ff[gi]);
      assign PORT7_SHARED_BITS_OE_OUT[gi] = drv_en(PULSE_GEN_OUT_EN_IN[gi],
        p7_dir_ff[gi]);

      chk_port_wave_off : assert property (
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P7_DATA) &&
         !PULSE_GEN_OUT_EN_IN[gi]) ##1 !PULSE_GEN_OUT_EN_IN[gi]
        |-> PORT7_SHARED_BITS_OUT[gi] == $past(REG_WDATA_IN[gi]))
      else $error("shared port7 bit does not follow port data");

      chk_wave_drives : assert property (
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        PULSE_GEN_OUT_EN_IN[gi] && !p7_dir_ff[gi]
        |-> PORT7_SHARED_BITS_OE_OUT[gi] &&
            PORT7_SHARED_BITS_OUT[gi] == PULSE_GEN_WAVE_IN[gi])
      else $error("enabled pulse wave not on its pin");
    end
  endgenerate

  // these pins only feed listening inputs, so the port keeps the driver
  assign PORT7_BIT6_OUT    = p7_data_ff[2];
  assign PORT7_BIT6_OE_OUT = p7_dir_ff[2];
  assign PORT8_BIT0_OUT    = p8_data_ff[0];
  assign PORT8_BIT0_OE_OUT = p8_dir_ff[0];
  assign PORT8_BIT1_OUT    = p8_data_ff[1];
  assign PORT8_BIT1_OE_OUT = p8_dir_ff[1];

  // open drain: a one releases the pin, a zero pulls it low
  assign PORT6_OPENDRAIN_BITS_OUT    = 8'h00;
  assign PORT6_OPENDRAIN_BITS_OE_OUT = ~ana_en_ff & ~p6_data_ff;
  assign ANALOG_IN_PINS_SEL_OUT      = ana_en_ff;

  ////////////////////////////////////////////////////////////////////////
  // peripheral inputs, sampled whatever drives the pin

  logic [7:0]      irq_pins;
  logic [7:0]      ext_irq_ff;
  logic [1:0]      tin_ff;
  logic            trig_ff;

  assign irq_pins = {b80_s, b76_s, sh_s, irq_low_s};

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ext_irq_ff <= 8'h00;
      tin_ff     <= 2'h0;
      trig_ff    <= 1'b0;
    end else begin
      ext_irq_ff <= irq_pins & EXT_IRQ_EN_IN;
      tin_ff     <= {b81_s, b80_s} & RELOAD_TIMER_EVENT_EN_IN;
      trig_ff    <= b76_s & CONV_TRIGGER_EN_IN;
    end
  end

  assign EXT_IRQ_OUT             = ext_irq_ff;
  assign RELOAD_TIMER0_EVENT_OUT = tin_ff[0];
  assign RELOAD_TIMER1_EVENT_OUT = tin_ff[1];
  assign CONV_TRIGGER_OUT        = trig_ff;

  ////////////////////////////////////////////////////////////////////////
  // drive conflict status: an input function listens while a driver is on

  logic [4:0]      conflict_ff;
  logic [4:0]      nxt_conflict;

  always_comb begin
    nxt_conflict = {
      RELOAD_TIMER_EVENT_EN_IN[1] & PORT8_BIT1_OE_OUT,
      (EXT_IRQ_EN_IN[7] | RELOAD_TIMER_EVENT_EN_IN[0]) & PORT8_BIT0_OE_OUT,
      (EXT_IRQ_EN_IN[6] | CONV_TRIGGER_EN_IN) & PORT7_BIT6_OE_OUT,
      EXT_IRQ_EN_IN[5:4] & PORT7_SHARED_BITS_OE_OUT};
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      conflict_ff <= `SPFS_RST_CONF;
    end else begin
      conflict_ff <= nxt_conflict;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode strap capture, once per reset release

  spfs_cap_state_t cap_ff;
  spfs_mode_t      mode_ff;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      cap_ff <= SPFS_CAP_FILL;
    end else begin
      case (cap_ff)
        SPFS_CAP_FILL: cap_ff <= SPFS_CAP_SYNC;
        SPFS_CAP_SYNC: cap_ff <= SPFS_CAP_TAKE;
        SPFS_CAP_TAKE: cap_ff <= SPFS_CAP_DONE;
        SPFS_CAP_DONE: cap_ff <= SPFS_CAP_DONE;
        default:       cap_ff <= SPFS_CAP_FILL;
      endcase
    end
  end

  // straps are tied on the board; later glitches must not change mode
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      mode_ff <= 3'h0;
    end else if (cap_ff == SPFS_CAP_TAKE) begin
      mode_ff <= mode_s;
    end
  end

  assign MODE_OUT       = mode_ff;
  assign MODE_VALID_OUT = (cap_ff == SPFS_CAP_DONE);

  ////////////////////////////////////////////////////////////////////////
  // register read

  spfs_byte_t      rdata_ff;
  spfs_byte_t      nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `SPFS_A_P6_DATA:   nxt_rdata = p6_data_ff;
        // digital input buffer is off for converter pins
        `SPFS_A_P6_PIN:    nxt_rdata = p6_s & ~ana_en_ff;
        `SPFS_A_P7_DATA:   nxt_rdata = {5'h00, p7_data_ff};
        `SPFS_A_P7_DIR:    nxt_rdata = {5'h00, p7_dir_ff};
        `SPFS_A_P7_PIN:    nxt_rdata = {5'h00, b76_s, sh_s};
        `SPFS_A_P8_DATA:   nxt_rdata = {6'h00, p8_data_ff};
        `SPFS_A_P8_DIR:    nxt_rdata = {6'h00, p8_dir_ff};
        `SPFS_A_P8_PIN:    nxt_rdata = {6'h00, b81_s, b80_s};
        `SPFS_A_ANA_EN:    nxt_rdata = ana_en_ff;
        `SPFS_A_MODE:      nxt_rdata = {4'h0, MODE_VALID_OUT, mode_ff};
        `SPFS_A_CONFLICT:  nxt_rdata = {3'h0, conflict_ff};
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA_OUT = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [1:0]      chk_age_ff;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      chk_age_ff <= 2'h0;
    end else if (chk_age_ff != `SPFS_AGE_MAX) begin
      chk_age_ff <= chk_age_ff + `SPFS_AGE_STEP;
    end
  end

  chk_od_low_only : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P6_DATA) ##1
    !$changed(ana_en_ff)
    |-> PORT6_OPENDRAIN_BITS_OUT == 8'h00 &&
        PORT6_OPENDRAIN_BITS_OE_OUT == (~$past(REG_WDATA_IN) & ~ana_en_ff))
  else $error("open drain port drives wrong level");

  chk_analog_undriven : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (PORT6_OPENDRAIN_BITS_OE_OUT & ANALOG_IN_PINS_SEL_OUT) == 8'h00)
  else $error("converter pin still driven");

  chk_irq_sampled : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    chk_age_ff == `SPFS_AGE_MAX
    |-> EXT_IRQ_OUT == ({$past(PORT8_BIT0_IN, 3), $past(PORT7_BIT6_IN, 3),
        $past(PORT7_SHARED_BITS_IN, 3), $past(EXT_IRQ_IN_LOW_IN, 3)} &
        $past(EXT_IRQ_EN_IN)))
  else $error("interrupt pin not sampled three cycles on");

  chk_timer_sampled : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    chk_age_ff == `SPFS_AGE_MAX
    |-> {RELOAD_TIMER1_EVENT_OUT, RELOAD_TIMER0_EVENT_OUT} ==
        ({$past(PORT8_BIT1_IN, 3), $past(PORT8_BIT0_IN, 3)} &
         $past(RELOAD_TIMER_EVENT_EN_IN)))
  else $error("timer event pin not sampled");

  chk_trigger_conflict : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    CONV_TRIGGER_EN_IN && PORT7_BIT6_OE_OUT |=> conflict_ff[2])
  else $error("driven trigger pin not flagged");

  chk_plain_port_dir : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_P8_DIR)
    |=> {PORT8_BIT1_OE_OUT, PORT8_BIT0_OE_OUT} == $past(REG_WDATA_IN[1:0]))
  else $error("plain port bit direction lost");

  chk_mode_held : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (chk_age_ff == `SPFS_AGE_MAX |-> MODE_VALID_OUT) and
    (MODE_VALID_OUT && $past(MODE_VALID_OUT) |-> $stable(MODE_OUT)))
  else $error("mode not captured or changed later");

  chk_ana_reset : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $past(!RST_N_IN) |-> ANALOG_IN_PINS_SEL_OUT == `SPFS_RST_ANA_EN)
  else $error("analog enable not analog after reset");

  chk_ana_follow : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    wr_hit(REG_WR_IN, REG_ADDR_IN, `SPFS_A_ANA_EN)
    |=> ANALOG_IN_PINS_SEL_OUT == $past(REG_WDATA_IN))
  else $error("pin function lags the analog enable write");

  chk_read_slot : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
  else $error("read data outside its slot");

endmodule : spfs_pin_mux

`default_nettype wire

// [tb/spfs_board_model.sv]
// Purpose: board side of the shared pin group
// Assumes: board drives every push-pull pin whenever the device lets go
// Notes:   port6 lines carry pull-ups; straps tied to fixed levels
`timescale 1ns/1ns
`default_nettype none

module spfs_board_model #(
  parameter logic [2:0] STRAP = 3'h5
) (
  // device drive side
  input  wire logic [4:0] pin_out_in,
  input  wire logic [4:0] pin_oe_in,
  input  wire logic [7:0] od_oe_in,
  // board stimulus
  input  wire logic [4:0] ext_lvl_in,
  // pin levels
  output logic      [4:0] pin_lvl_out,
  output logic      [7:0] od_lvl_out,
  output logic      [2:0] strap_out
);
  // board steps back while the device drives, so the two never fight
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_lvl_in);
  // pull-up gives high unless the device sinks the line
  assign od_lvl_out  = ~od_oe_in;
  assign strap_out   = STRAP;
endmodule : spfs_board_model

`default_nettype wire

// [tb/shared_pin_function_select_tb_top.sv]
// Purpose: register-driven test of the shared pin function select block
// Assumes: pin index 0,1 port7 shared, 2 bit6, 3,4 port8 bits
// Notes:   peripheral enables and waveforms driven directly by the bench
`include "spfs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module shared_pin_function_select_tb_top;
  import spfs_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic       clk, rst_n, wr, rd, trg_en, trg, t0, t1, mvalid;
  logic [7:0] addr, irq_en, irq, sel, od_out, od_oe, od_lvl;
  spfs_byte_t wdata, rdata;
  spfs_mode_t mode;
  logic [1:0] wave, gen_en, tmr_en;
  logic [3:0] irq_low;
  logic [4:0] p_out, p_oe, p_lvl, ext;
  logic [2:0] strap;
  int         err_total, total_checks;

  spfs_pin_mux DUT (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .PULSE_GEN_WAVE_IN(wave),
    .PULSE_GEN_OUT_EN_IN(gen_en), .EXT_IRQ_EN_IN(irq_en), .RELOAD_TIMER_EVENT_EN_IN(tmr_en),
    .CONV_TRIGGER_EN_IN(trg_en), .EXT_IRQ_OUT(irq), .RELOAD_TIMER0_EVENT_OUT(t0),
    .RELOAD_TIMER1_EVENT_OUT(t1), .CONV_TRIGGER_OUT(trg), .ANALOG_IN_PINS_SEL_OUT(sel),
    .MODE_OUT(mode), .MODE_VALID_OUT(mvalid), .EXT_IRQ_IN_LOW_IN(irq_low),
    .PORT7_SHARED_BITS_IN(p_lvl[1:0]), .PORT7_SHARED_BITS_OUT(p_out[1:0]),
    .PORT7_SHARED_BITS_OE_OUT(p_oe[1:0]), .PORT7_BIT6_IN(p_lvl[2]),
    .PORT7_BIT6_OUT(p_out[2]), .PORT7_BIT6_OE_OUT(p_oe[2]),
    .PORT6_OPENDRAIN_BITS_IN(od_lvl), .PORT6_OPENDRAIN_BITS_OUT(od_out),
    .PORT6_OPENDRAIN_BITS_OE_OUT(od_oe), .PORT8_BIT0_IN(p_lvl[3]), .PORT8_BIT0_OUT(p_out[3]),
    .PORT8_BIT0_OE_OUT(p_oe[3]), .PORT8_BIT1_IN(p_lvl[4]), .PORT8_BIT1_OUT(p_out[4]),
    .PORT8_BIT1_OE_OUT(p_oe[4]), .MODE_SELECT_PINS_IN(strap)
  );

  spfs_board_model #(.STRAP(STRAP)) board (
    .pin_out_in(p_out), .pin_oe_in(p_oe), .od_oe_in(od_oe), .ext_lvl_in(ext),
    .pin_lvl_out(p_lvl), .od_lvl_out(od_lvl), .strap_out(strap)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // two synchroniser flops plus the output flop
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] ge, eo;
    err_total = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {wr, rd, trg_en, addr, wdata, wave, gen_en, tmr_en, irq_en, irq_low} = '0;
    ext = 5'h1f;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(sel, 8'hff);
    chk(od_oe, 8'h00);
    // strap capture needs three edges after release before the mode reads valid
    settle();
    rd_chk(`SPFS_A_ANA_EN, `SPFS_RST_ANA_EN);
    rd_chk(`SPFS_A_MODE, {4'h0, 1'b1, STRAP});
    chk({4'h0, mvalid, mode}, {4'h0, 1'b1, STRAP});
    wr_reg(`SPFS_A_MODE, 8'h00);
    rd_chk(`SPFS_A_MODE, {4'h0, 1'b1, STRAP});
    rd_chk(8'h3c, 8'h00);
    // analog split: low nibble to converter, high nibble open-drain port
    wr_reg(`SPFS_A_ANA_EN, 8'h0f);
    chk(sel, 8'h0f);
    wr_reg(`SPFS_A_P6_DATA, 8'ha0);
    chk(od_oe, 8'h50);
    chk(od_out, 8'h00);
    settle();
    rd_chk(`SPFS_A_P6_PIN, 8'ha0);
    wr_reg(`SPFS_A_ANA_EN, 8'hff);
    chk(od_oe, 8'h00);
    // waveform override per generator, every enable combination
    wr_reg(`SPFS_A_P7_DATA, 8'h05);
    wr_reg(`SPFS_A_P7_DIR, 8'h00);
    wave <= 2'b10;
    for (int e = 0; e < 4; e++) begin
      @(posedge clk);
      gen_en <= e[1:0];
      @(posedge clk);
      #1;
      ge = e[1:0];
      eo = (ge & 2'b10) | (~ge & 2'b01);
      chk({6'h0, p_out[1:0]}, {6'h0, eo});
      chk({6'h0, p_oe[1:0]}, {6'h0, ge});
    end
    @(posedge clk);
    gen_en  <= 2'b00;
    irq_en  <= 8'hff;
    trg_en  <= 1'b1;
    tmr_en  <= 2'b11;
    irq_low <= 4'ha;
    wr_reg(`SPFS_A_P7_DIR, 8'h04);
    wr_reg(`SPFS_A_P8_DIR, 8'h03);
    wr_reg(`SPFS_A_P8_DATA, 8'h02);
    chk({5'h0, p_oe[4:2]}, 8'h07);
    chk({5'h0, p_out[4:2]}, 8'h05);
    settle();
    chk(irq, 8'h7a);
    chk({6'h0, t1, t0}, 8'h02);
    chk({7'h0, trg}, 8'h01);
    rd_chk(`SPFS_A_CONFLICT, 8'h1c);
    @(posedge clk);
    irq_en <= 8'h00;
    tmr_en <= 2'b00;
    trg_en <= 1'b0;
    settle();
    chk({irq[7:4], 2'h0, t1, trg}, 8'h00);
    chk({5'h0, p_oe[4:2]}, 8'h07);
    @(posedge clk);
    irq_en  <= 8'hff;
    ext     <= 5'h00;
    irq_low <= 4'h5;
    settle();
    chk(irq, 8'h45);
    @(posedge clk);
    gen_en <= 2'b11;
    settle();
    chk(irq, 8'h65);
    rd_chk(`SPFS_A_CONFLICT, 8'h0f);
    // second reset in mid-run brings the analog selection and port7 data back
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(sel, 8'hff);
    rd_chk(`SPFS_A_P7_DATA, 8'h00);
    wrap_up();
  end

  // tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : shared_pin_function_select_tb_top

`default_nettype wire
